/* verilog/ascp_pkg.sv */
// constants and types shared by the converter serial control port
package ascp_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int INT_CONV_TIME_NS = 7500;
    localparam int INT_CONV_CYCLES = (INT_CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESULT_W = 14;
    localparam int TIMER_W = 8;
    localparam int CNT_W = 5;
    // pin positions inside the synchroniser vectors
    localparam int PIN_SCLK = 0;
    localparam int PIN_CS_N = 1;
    localparam int PIN_DIN = 2;
    localparam int PIN_SHUTDOWN_N_N = 3;
    localparam int PIN_W = 4;
    // falling-edge numbers counted from the start bit
    localparam logic [CNT_W-1:0] FALL_CTRL_DONE = 5'h08;
    localparam logic [CNT_W-1:0] FALL_MSB = 5'h0A;
    localparam logic [CNT_W-1:0] FALL_CONV_DONE = 5'h12;
    localparam logic [CNT_W-1:0] BITS_CTRL = 5'h08;
    // clock and power mode encodings
    localparam logic [1:0] MODE_FULL_PD = 2'h0;
    localparam logic [1:0] MODE_FAST_PD = 2'h1;
    localparam logic [1:0] MODE_INT_CLK = 2'h2;
    localparam logic [1:0] MODE_EXT_CLK = 2'h3;

    typedef struct packed {
        logic start;
        logic [2:0] channel_select;
        logic single_or_differential;
        logic unipolar_or_bipolar;
        logic power_clock_mode_hi;
        logic power_clock_mode_lo;
    } ascp_ctrl_t;

    localparam ascp_ctrl_t CTRL_RESET = ascp_ctrl_t'(8'h00);

    typedef enum logic [2:0] {
        ST_HUNT,
        ST_CTRL,
        ST_EXT_CONV,
        ST_INT_CONV,
        ST_SHIFT
    } ascp_state_t;

    typedef struct packed {
        logic [PIN_W-1:0] sy1;
        logic [PIN_W-1:0] sy2;
        logic [PIN_W-1:0] sy3;
        logic [PIN_W-1:0] flt;
        ascp_state_t st;
        logic [7:0] sreg;
        logic [CNT_W-1:0] cnt;
        logic [RESULT_W-1:0] shreg;
        logic [TIMER_W-1:0] timer;
        ascp_ctrl_t ctrl;
        logic ext_mode;
        logic busy;
        logic dout;
        logic dout_oe;
        logic strobe;
        logic strobe_oe;
        logic shutdown;
    } ascp_regs_t;
endpackage

/* verilog/ascp_port.sv */
// serial control and readout port of a multichannel converter
// Operation
// - result bits change on falling edge; tristate while deselected
// - input bits sampled on rising serial clock
// - nothing captured while chip select high
// - internal mode strobe low during conversion
// - external mode strobe high two periods
// - external mode strobe tristate while deselected
// - serial clock paces external conversion
// - shutdown input low halts the port
// - first one after select is start bit
// - control byte fields channel, input, polarity, mode
// - external conversion ends on eighteenth falling edge
`timescale 1ns/10ps
`default_nettype none
module ascp_port
    import ascp_pkg::*;
(
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    // serial pins
    input wire logic SCLK_IN,
    input wire logic CS_N_IN,
    input wire logic DIN_IN,
    input wire logic SHUTDOWN_N_IN,
    output logic DOUT_OUT,
    output logic DOUT_OE_OUT,
    output logic CONVERSION_STROBE_OUT,
    output logic CONVERSION_STROBE_OE_OUT,
    // converter side
    input wire logic [RESULT_W-1:0] RESULT_IN,
    output logic [2:0] CHANNEL_OUT,
    output logic SINGLE_ENDED_OUT,
    output logic UNIPOLAR_OUT,
    output logic [1:0] MODE_OUT,
    output logic BUSY_OUT,
    output logic SHUTDOWN_OUT
);
    ascp_regs_t r;
    ascp_regs_t n;
    logic [PIN_W-1:0] agree;
    logic [PIN_W-1:0] flt_new;
    logic rise;
    logic fall;
    logic sel;
    logic [CNT_W-1:0] fnum;
    ascp_ctrl_t byte_in;

    always_comb begin
        n = r;
        n.sy1 = {SHUTDOWN_N_IN, DIN_IN, CS_N_IN, SCLK_IN};
        n.sy2 = r.sy1;
        n.sy3 = r.sy2;
        agree = ~(r.sy2 ^ r.sy3);
        flt_new = (r.sy2 & agree) | (r.flt & ~agree);
        n.flt = flt_new;
        sel = ~flt_new[PIN_CS_N];
        rise = sel & flt_new[PIN_SCLK] & ~r.flt[PIN_SCLK];
        fall = sel & ~flt_new[PIN_SCLK] & r.flt[PIN_SCLK];
        fnum = r.cnt + 5'h01;
        byte_in = ascp_ctrl_t'({r.sreg[6:0], flt_new[PIN_DIN]});
        if (fall) begin
            n.cnt = fnum;
        end
        case (r.st)
            ST_HUNT: begin
                if (rise && flt_new[PIN_DIN]) begin
                    n.st = ST_CTRL;
                    n.sreg = 8'h01;
                    n.cnt = '0;
                end
            end
            ST_CTRL: begin
                if (rise) begin
                    n.sreg = byte_in;
                end
                if (fall && fnum == FALL_CTRL_DONE) begin
                    n.ctrl = ascp_ctrl_t'(r.sreg);
                    n.ext_mode = (r.sreg[1:0] == MODE_EXT_CLK);
                    case (r.sreg[1:0])
                        MODE_EXT_CLK: begin
                            n.st = ST_EXT_CONV;
                            n.busy = 1'b1;
                            n.strobe = 1'b1;
                        end
                        MODE_INT_CLK: begin
                            n.st = ST_INT_CONV;
                            n.busy = 1'b1;
                            n.strobe = 1'b0;
                            n.timer = TIMER_W'(INT_CONV_CYCLES);
                        end
                        default: begin
                            n.st = ST_HUNT;
                        end
                    endcase
                end
            end
            ST_EXT_CONV: begin
                if (fall && fnum == FALL_MSB) begin
                    n.strobe = 1'b0;
                    n.dout = RESULT_IN[RESULT_W-1];
                    n.shreg = {RESULT_IN[RESULT_W-2:0], 1'b0};
                end else if (fall && fnum > FALL_MSB) begin
                    n.dout = r.shreg[RESULT_W-1];
                    n.shreg = {r.shreg[RESULT_W-2:0], 1'b0};
                    if (fnum == FALL_CONV_DONE) begin
                        n.busy = 1'b0;
                        n.st = ST_SHIFT;
                    end
                end
            end
            ST_INT_CONV: begin
                if (r.timer == '0) begin
                    n.strobe = 1'b1;
                    n.busy = 1'b0;
                    n.shreg = RESULT_IN;
                    n.st = ST_SHIFT;
                end else begin
                    n.timer = r.timer - 8'h01;
                end
            end
            ST_SHIFT: begin
                if (fall) begin
                    n.dout = r.shreg[RESULT_W-1];
                    n.shreg = {r.shreg[RESULT_W-2:0], 1'b0};
                end
                if (rise && flt_new[PIN_DIN]) begin
                    n.st = ST_CTRL;
                    n.sreg = 8'h01;
                    n.cnt = '0;
                end
            end
            default: begin
                n.st = ST_HUNT;
            end
        endcase
        // deselect aborts the frame; an internal conversion keeps running
        if (!sel && r.st != ST_INT_CONV) begin
            n.st = ST_HUNT;
            n.dout = 1'b0;
            n.busy = 1'b0;
            if (r.ext_mode) begin
                n.strobe = 1'b0;
            end
        end
        n.dout_oe = sel;
        n.strobe_oe = r.ext_mode ? sel : 1'b1;
        n.shutdown = ~flt_new[PIN_SHUTDOWN_N_N];
        if (n.shutdown) begin
            n.st = ST_HUNT;
            n.busy = 1'b0;
            n.dout = 1'b0;
            n.dout_oe = 1'b0;
            n.strobe = ~r.ext_mode;
            n.strobe_oe = 1'b0;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            r <= '{sy1: '1, sy2: '1, sy3: '1, flt: '1, st: ST_HUNT, sreg: '0, cnt: '0,
                   shreg: '0, timer: '0, ctrl: CTRL_RESET, ext_mode: 1'b0, busy: 1'b0,
                   dout: 1'b0, dout_oe: 1'b0, strobe: 1'b1, strobe_oe: 1'b1,
                   shutdown: 1'b0};
        end else begin
            r <= n;
        end
    end

    assign DOUT_OUT = r.dout;
    assign DOUT_OE_OUT = r.dout_oe;
    assign CONVERSION_STROBE_OUT = r.strobe;
    assign CONVERSION_STROBE_OE_OUT = r.strobe_oe;
    assign CHANNEL_OUT = r.ctrl.channel_select;
    assign SINGLE_ENDED_OUT = r.ctrl.single_or_differential;
    assign UNIPOLAR_OUT = r.ctrl.unipolar_or_bipolar;
    assign MODE_OUT = {r.ctrl.power_clock_mode_hi, r.ctrl.power_clock_mode_lo};
    assign BUSY_OUT = r.busy;
    assign SHUTDOWN_OUT = r.shutdown;

    // checks
    property p_dout_oe;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        r.flt[PIN_CS_N] |-> !DOUT_OE_OUT;
    endproperty
    a_dout_oe: assert property (p_dout_oe) else $error("data out driven while deselected");
    property p_dout_edge;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        $changed(DOUT_OUT) && !SHUTDOWN_OUT |-> $past(fall) || !$past(sel);
    endproperty
    a_dout_edge: assert property (p_dout_edge) else $error("data out moved off a falling edge");
    property p_no_capture;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        r.st == ST_CTRL && !sel |=> r.st == ST_HUNT;
    endproperty
    a_no_capture: assert property (p_no_capture) else $error("frame kept while deselected");
    property p_int_strobe;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        r.st == ST_INT_CONV && !r.shutdown |-> !CONVERSION_STROBE_OUT && BUSY_OUT;
    endproperty
    a_int_strobe: assert property (p_int_strobe) else $error("strobe high during conversion");
    property p_int_done;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        r.st == ST_INT_CONV && r.timer == '0 && !n.shutdown |=> CONVERSION_STROBE_OUT && !BUSY_OUT;
    endproperty
    a_int_done: assert property (p_int_done) else $error("strobe not raised at end");
    property p_ext_strobe;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        r.st == ST_EXT_CONV && fall && sel && !n.shutdown && fnum == FALL_MSB
        |=> !CONVERSION_STROBE_OUT && $past(CONVERSION_STROBE_OUT);
    endproperty
    a_ext_strobe: assert property (p_ext_strobe) else $error("strobe pulse length wrong");
    property p_ext_oe;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        r.ext_mode && !sel |=> !CONVERSION_STROBE_OE_OUT;
    endproperty
    a_ext_oe: assert property (p_ext_oe) else $error("strobe driven while deselected");
    property p_shutdown_n;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        r.shutdown |-> r.st == ST_HUNT && !DOUT_OE_OUT && !BUSY_OUT;
    endproperty
    a_shutdown_n: assert property (p_shutdown_n) else $error("active during shutdown");
    property p_ext_end;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        r.st == ST_EXT_CONV && fall && sel && !n.shutdown && fnum == FALL_CONV_DONE
        |=> !BUSY_OUT && r.st == ST_SHIFT;
    endproperty
    a_ext_end: assert property (p_ext_end) else $error("conversion not ended on edge 18");
    c_ext: cover property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        r.st == ST_EXT_CONV ##1 r.st == ST_SHIFT);
    c_int: cover property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        r.st == ST_INT_CONV ##1 r.st == ST_SHIFT);
    c_shutdown_n: cover property (@(posedge CLK_IN) disable iff (!RST_N_IN)
        r.st == ST_CTRL ##1 r.shutdown);
endmodule
`default_nettype wire

/* tb/ascp_host.sv */
// host serial master model for the converter port
`timescale 1ns/10ps
`default_nettype none
module ascp_host
    import ascp_pkg::*;
(
    // serial pins driven by the host
    output logic SCLK_OUT,
    output logic CS_N_OUT,
    output logic DIN_OUT,
    // pins observed by the host
    input wire logic DOUT_IN,
    input wire logic STROBE_IN,
    input wire logic BUSY_IN
);
    // per period: dout, strobe, busy seen just before the falling edge
    logic [2:0] smp [0:24];

    initial begin
        SCLK_OUT = 1'b0;
        CS_N_OUT = 1'b1;
        DIN_OUT = 1'b0;
    end

    // data set while low, held across the rise, outputs read before the fall
    task automatic tick(input logic d, input int k);
        DIN_OUT = d;
        #160;
        SCLK_OUT = 1'b1;
        #160;
        smp[k] = {DOUT_IN, STROBE_IN, BUSY_IN};
        SCLK_OUT = 1'b0;
    endtask

    task automatic send(input logic [7:0] ctl, input int lead);
        CS_N_OUT = 1'b0;
        #200;
        repeat (lead) tick(1'b0, 0);
        for (int i = 7; i >= 0; i--) tick(ctl[i], 8 - i);
    endtask

    // cut frame: only the first nb bits of a byte, then deselect
    task automatic cut(input logic [7:0] ctl, input int nb);
        CS_N_OUT = 1'b0;
        #200;
        for (int i = 7; i > 7 - nb; i--) tick(ctl[i], 8 - i);
        release_bus();
    endtask

    // keeps clocking so an external conversion can advance
    task automatic run(input int a, input int b);
        for (int k = a; k <= b; k++) tick(1'b0, k);
    endtask

    // released data line shows the inverse of its last value
    task automatic release_bus();
        #200;
        CS_N_OUT = 1'b1;
        DIN_OUT = ~DIN_OUT;
        #400;
    endtask
endmodule
`default_nettype wire

/* tb/ascp_port_tb_top.sv */
// self-checking bench for the converter serial control port
`timescale 1ns/10ps
`default_nettype none
module ascp_port_tb_top
    import ascp_pkg::*;
;
    logic clk, rst_n, shutdown_n_n, sclk, cs_n, din;
    logic dout, dout_oe, strb, strb_oe, sgl, uni, busy, shutdown_n_o;
    logic [2:0] chan;
    logic [1:0] mode;
    logic [RESULT_W-1:0] result, got;
    logic [7:0] ctl;
    logic [15:0] lfsr = 16'h001F;
    int error_cnt = 0;
    int checks = 0;
    int cycles = 0;
    int b;

    ascp_port dut (.CLK_IN(clk), .RST_N_IN(rst_n), .SCLK_IN(sclk), .CS_N_IN(cs_n),
        .DIN_IN(din), .SHUTDOWN_N_IN(shutdown_n_n), .DOUT_OUT(dout), .DOUT_OE_OUT(dout_oe),
        .CONVERSION_STROBE_OUT(strb), .CONVERSION_STROBE_OE_OUT(strb_oe),
        .RESULT_IN(result), .CHANNEL_OUT(chan), .SINGLE_ENDED_OUT(sgl),
        .UNIPOLAR_OUT(uni), .MODE_OUT(mode), .BUSY_OUT(busy), .SHUTDOWN_OUT(shutdown_n_o));

    ascp_host host (.SCLK_OUT(sclk), .CS_N_OUT(cs_n), .DIN_OUT(din), .DOUT_IN(dout),
        .STROBE_IN(strb), .BUSY_IN(busy));

    function automatic logic [15:0] next_rand(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic chk(input logic [13:0] g, input logic [13:0] e, input string what);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, g, e);
        end
    endtask

    task automatic stop_test();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            error_cnt++;
            stop_test();
        end
    end

    initial begin
        rst_n = 1'b0;
        shutdown_n_n = 1'b1;
        result = 14'h0000;
        repeat (20) @(posedge clk);
        #1;
        rst_n = 1'b1;
        #160;
        for (int n = 0; n < 8; n++) begin
            lfsr = next_rand(lfsr);
            ctl = {1'b1, lfsr[6:2], n[1:0]};
            result = lfsr[15:2];
            if (n == 7) begin
                shutdown_n_n = 1'b0;
                #400;
                chk({shutdown_n_o, dout_oe, strb_oe}, 3'b100, "shutdown");
                shutdown_n_n = 1'b1;
                #400;
                chk(shutdown_n_o, 1'b0, "wake");
            end
            host.send(ctl, n % 3);
            b = 0;
            if (ctl[1:0] == MODE_EXT_CLK) begin
                host.run(9, 24);
                chk({host.smp[9][1], host.smp[10][1], host.smp[11][1]}, 3'b110, "pulse");
                chk({host.smp[18][0], host.smp[19][0]}, 2'b10, "ext end");
                chk({dout_oe, strb_oe}, 2'b11, "selected drive");
                b = 11;
            end else if (ctl[1:0] == MODE_INT_CLK) begin
                #400;
                chk({strb, busy, dout_oe}, 3'b011, "int start");
                for (int w = 0; w < 300 && strb !== 1'b1; w++) begin
                    @(posedge clk);
                    #1;
                end
                chk({strb, busy}, 2'b10, "int done");
                host.run(1, 15);
                b = 2;
            end
            if (b > 0) begin
                for (int i = 0; i < RESULT_W; i++) got[13 - i] = host.smp[b + i][2];
                chk(got, result, "result");
            end
            host.release_bus();
            chk({chan, sgl, uni, mode, busy}, {ctl[6:0], 1'b0}, "control");
            chk({dout_oe, strb_oe}, {1'b0, ctl[1:0] != MODE_EXT_CLK}, "release");
        end
        repeat (8) host.tick(1'b1, 0);
        #400;
        chk({chan, sgl, uni, mode}, ctl[6:0], "deselected");
        host.cut({1'b1, ~ctl[6:0]}, 5);
        chk({chan, sgl, uni, mode, busy}, {ctl[6:0], 1'b0}, "cut frame");
        ctl = 8'hD5;
        host.send(ctl, 1);
        host.release_bus();
        chk({chan, sgl, uni, mode, busy}, {ctl[6:0], 1'b0}, "after cut");
        stop_test();
    end
endmodule
`default_nettype wire
